// ### design/ccd_ctrl_map.vh
// constants for the serial-memory page and refresh controller
`ifndef CCD_CTRL_MAP_VH
`define CCD_CTRL_MAP_VH
`define PAGE_COUNT 9'h100
`define STROBE_DIV 3'h4
`define SENSE_HALF_NS 16'h0028
`define CLK_NS 16'h0008
`define SENSE_HALF_CYC (`SENSE_HALF_NS / `CLK_NS)
`define REFRESH_DIV_DEF 16'h0100
`define PAGE_LIMIT_DEF 16'h0200
`define BURST_LEN_DEF 9'h020
`define BUSY_DECODE 16'h01f0
`define MODE_BURST 2'h0
`define MODE_DIST 2'h1
`define MODE_ADAPT 2'h2
`endif

// ### design/sense_clock_gen.v
// sense clock and array shift strobe generator with clock enable
`timescale 1ns/1ps
`default_nettype none
`include "ccd_ctrl_map.vh"
module sense_clock_gen (
  input wire clk,
  input wire rst,
  input wire run,
  output reg sense_ff,
  output reg strobe_ff,
  output reg cycle_done_ff
);
  reg [15:0] half_ff;
  reg [1:0] phase_ff;
  always @(posedge clk) begin
    cycle_done_ff <= 1'b0;
    if (rst) begin
      half_ff <= 16'h0000;
      phase_ff <= 2'h0;
      sense_ff <= 1'b0;
      strobe_ff <= 1'b0;
    end else if (half_ff != 16'h0000) begin
      half_ff <= half_ff - 16'h0001;
    end else if (sense_ff) begin
      // falling edge ends one sense cycle; strobe drops with it
      sense_ff <= 1'b0;
      strobe_ff <= 1'b0;
      half_ff <= `SENSE_HALF_CYC - 16'h0001;
      phase_ff <= phase_ff + 2'h1;
      cycle_done_ff <= 1'b1;
    end else if (run) begin
      sense_ff <= 1'b1;
      strobe_ff <= (phase_ff == 2'h3);
      half_ff <= `SENSE_HALF_CYC - 16'h0001;
    end
  end
endmodule // sense_clock_gen
`default_nettype wire

// ### design/adaptive_counters.v
// refresh and page-time counters for adaptive refresh
`timescale 1ns/1ps
`default_nettype none
`include "ccd_ctrl_map.vh"
module adaptive_counters (
  input wire clk,
  input wire rst,
  input wire osc_tick,
  input wire sense_cycle,
  input wire [15:0] page_limit,
  output reg refresh_demand_ff,
  output reg page_change_ff,
  output reg busy_decode_ff
);
  reg [15:0] refresh_cnt_ff;
  reg [15:0] page_time_ff;
  reg [15:0] nxt_refresh_cnt;
  always @* begin
    nxt_refresh_cnt = refresh_cnt_ff;
    if (osc_tick && !sense_cycle) begin
      nxt_refresh_cnt = refresh_cnt_ff + 16'h0001;
    end else if (!osc_tick && sense_cycle && refresh_cnt_ff != 16'h0000) begin
      nxt_refresh_cnt = refresh_cnt_ff - 16'h0001;
    end
  end
  always @(posedge clk) begin
    if (rst) begin
      refresh_cnt_ff <= 16'h0000;
      page_time_ff <= 16'h0000;
      refresh_demand_ff <= 1'b0;
      page_change_ff <= 1'b0;
      busy_decode_ff <= 1'b0;
    end else begin
      refresh_cnt_ff <= nxt_refresh_cnt;
      refresh_demand_ff <= (nxt_refresh_cnt != 16'h0000);
      if (sense_cycle) begin
        page_time_ff <= 16'h0000;
      end else if (osc_tick && page_time_ff != page_limit) begin
        page_time_ff <= page_time_ff + 16'h0001;
      end
      page_change_ff <= (page_time_ff == page_limit);
      busy_decode_ff <= (page_time_ff >= `BUSY_DECODE);
    end
  end
endmodule // adaptive_counters
`default_nettype wire

// ### design/ccd_page_refresh_controller.v
// page, search and refresh controller for a short-loop serial memory
// Function
// - one shift strobe per four sense clocks
// - write strobe low no later than select
// - eight-bit register address port
// - burst refresh of 256/b fast clocks
// - distributed refresh: one clock per period/256
// - adaptive refresh takes over when limits near
// - counters clocked by temperature oscillator
// - refresh counter up tick, down sense
// - page-time counter clears on sense, carry forces
// - page counter tracks current page position
// - host loads target, compared with counter
// - match stops clocks, signals host ready
// - search fast, refresh slow; here both run at the same sense clock rate from sense_clock_gen
// - clock enable halts or runs clocks
// - plain square sense clock is allowed
// - ready/busy indication to host
// - busy from page change or decode
// - select only when sense and strobe low
// - short sense-low time limits serial select
// - page mode with counter address preferred
// - keep select active minimum time
// - idle clock rate lowered to minimum
// - address register buffers host address; with serial_mode high mem_addr takes access_addr directly, bypassing it
`timescale 1ns/1ps
`default_nettype none
`include "ccd_ctrl_map.vh"
module ccd_page_refresh_controller (
  input wire clk,
  input wire rst,
  input wire [1:0] refresh_mode,
  input wire osc_tick,
  input wire [15:0] refresh_div,
  input wire [8:0] burst_len,
  input wire [15:0] page_limit,
  input wire search_req,
  input wire [7:0] target_page,
  input wire access_req,
  input wire access_write,
  input wire serial_mode,
  input wire [7:0] access_addr,
  input wire access_din,
  input wire mem_dout,
  output reg sense_clock,
  output reg shift_strobe,
  output reg chip_select_n,
  output reg write_n,
  output reg [7:0] mem_addr,
  output reg mem_din,
  output reg mem_din_oe,
  output reg [7:0] page_pos,
  output reg ready,
  output reg busy,
  output reg page_found,
  output reg access_done,
  output reg access_dout
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_SEARCH = 5'h02;
  localparam [4:0] ST_REFRESH = 5'h04;
  localparam [4:0] ST_ACCESS = 5'h08;
  localparam [4:0] ST_FINISH = 5'h10;
  reg [4:0] state_ff;
  reg [4:0] nxt_state;
  reg [7:0] target_ff;
  reg [7:0] page_ff;
  reg [7:0] addr_ff;
  reg write_ff;
  reg din_ff;
  reg [15:0] dist_cnt_ff;
  reg dist_due_ff;
  reg [8:0] burst_left_ff;
  reg [8:0] nxt_burst_left;
  reg run;
  wire sense_w;
  wire strobe_w;
  wire cycle_done;
  wire refresh_demand;
  wire page_change;
  wire busy_decode;
  wire need_refresh;
  wire clocks_low;
  sense_clock_gen u_clk (
    .clk(clk),
    .rst(rst),
    .run(run),
    .sense_ff(sense_w),
    .strobe_ff(strobe_w),
    .cycle_done_ff(cycle_done)
  );
  adaptive_counters u_adapt (
    .clk(clk),
    .rst(rst),
    .osc_tick(osc_tick),
    .sense_cycle(cycle_done),
    .page_limit(page_limit),
    .refresh_demand_ff(refresh_demand),
    .page_change_ff(page_change),
    .busy_decode_ff(busy_decode)
  );
  // distributed refresh divider on the oscillator ticks
  always @(posedge clk) begin
    if (rst) begin
      dist_cnt_ff <= 16'h0000;
      dist_due_ff <= 1'b0;
    end else begin
      if (osc_tick) begin
        if (dist_cnt_ff >= refresh_div - 16'h0001) begin
          dist_cnt_ff <= 16'h0000;
          dist_due_ff <= 1'b1;
        end else begin
          dist_cnt_ff <= dist_cnt_ff + 16'h0001;
        end
      end
      if (state_ff == ST_REFRESH && cycle_done && !(osc_tick &&
          dist_cnt_ff >= refresh_div - 16'h0001)) begin
        dist_due_ff <= 1'b0;
      end
    end
  end
  // refresh need by selected method
  assign need_refresh = (refresh_mode == `MODE_DIST) ? dist_due_ff :
    (refresh_mode == `MODE_ADAPT) ? (refresh_demand | page_change) :
    dist_due_ff; // burst triggered by same period tick
  assign clocks_low = !sense_w && !strobe_w;
  always @* begin
    nxt_state = state_ff;
    nxt_burst_left = burst_left_ff;
    run = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        // idle: no clocks unless refresh is due
        if (need_refresh) begin
          nxt_state = ST_REFRESH;
          nxt_burst_left = (refresh_mode == `MODE_BURST) ? burst_len : 9'h001;
        end else if (search_req) begin
          nxt_state = ST_SEARCH;
        end else if (access_req) begin
          nxt_state = ST_ACCESS;
        end
      end
      ST_SEARCH: begin
        run = (page_ff != target_ff);
        if (page_ff == target_ff && clocks_low) begin
          nxt_state = ST_FINISH;
        end
      end
      ST_REFRESH: begin
        run = (burst_left_ff != 9'h000);
        if (cycle_done && burst_left_ff != 9'h000) begin
          nxt_burst_left = burst_left_ff - 9'h001;
        end
        if (burst_left_ff == 9'h000 && clocks_low) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ACCESS: begin
        // clocks halted for page access
        if (clocks_low) begin
          nxt_state = ST_FINISH;
        end
      end
      ST_FINISH: begin
        nxt_state = ST_IDLE;
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
  end
  always @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      burst_left_ff <= 9'h000;
      target_ff <= 8'h00;
      page_ff <= 8'h00;
      addr_ff <= 8'h00;
      write_ff <= 1'b0;
      din_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      burst_left_ff <= nxt_burst_left;
      if (state_ff == ST_IDLE && search_req) begin
        target_ff <= target_page;
      end
      if (state_ff == ST_IDLE && access_req) begin
        addr_ff <= access_addr;
        write_ff <= access_write;
        din_ff <= access_din;
      end
      if (cycle_done) begin
        page_ff <= page_ff + 8'h01;
      end
    end
  end
  // outputs all registered
  always @(posedge clk) begin
    if (rst) begin
      sense_clock <= 1'b0;
      shift_strobe <= 1'b0;
      chip_select_n <= 1'b1;
      write_n <= 1'b1;
      mem_addr <= 8'h00;
      mem_din <= 1'b0;
      mem_din_oe <= 1'b0;
      page_pos <= 8'h00;
      ready <= 1'b0;
      busy <= 1'b0;
      page_found <= 1'b0;
      access_done <= 1'b0;
      access_dout <= 1'b0;
    end else begin
      sense_clock <= sense_w;
      shift_strobe <= strobe_w;
      page_pos <= page_ff;
      mem_addr <= serial_mode ? access_addr : addr_ff;
      // select one cycle, only with clocks low
      chip_select_n <= !(state_ff == ST_ACCESS && clocks_low);
      write_n <= !(state_ff == ST_ACCESS && write_ff);
      mem_din <= din_ff;
      mem_din_oe <= (state_ff == ST_ACCESS) && write_ff;
      page_found <= (state_ff == ST_SEARCH) && (nxt_state == ST_FINISH);
      access_done <= (state_ff == ST_ACCESS) && (nxt_state == ST_FINISH);
      // read data captured during a selected read, then held
      if (!chip_select_n && write_n) begin
        access_dout <= mem_dout;
      end
      busy <= (state_ff != ST_IDLE) || page_change || busy_decode;
      ready <= (state_ff == ST_IDLE) && !page_change && !busy_decode;
    end
  end
endmodule // ccd_page_refresh_controller
`default_nettype wire

// ### dv/ccd_ctrl_monitor.sv
// concurrent checks on the controller memory-side and host-side outputs
`timescale 1ns/1ps
`default_nettype none
module ccd_ctrl_monitor (
  input wire logic clk,
  input wire logic rst,
  input wire logic sense_clock,
  input wire logic shift_strobe,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic [7:0] page_pos,
  input wire logic page_found,
  input wire logic ready,
  input wire logic busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic sense_q_ff;
  logic strobe_q_ff;
  logic seen_ff;
  logic [2:0] cnt_ff;
  // sense falls since last strobe rise
  always_ff @(posedge clk) begin
    sense_q_ff <= sense_clock;
    strobe_q_ff <= shift_strobe;
    if (rst) begin
      cnt_ff <= 3'h0;
      seen_ff <= 1'b0;
    end else if (shift_strobe && !strobe_q_ff) begin
      cnt_ff <= 3'h0;
      seen_ff <= 1'b1;
    end else if (sense_q_ff && !sense_clock) begin
      cnt_ff <= cnt_ff + 3'h1;
    end
  end
  a_select_clocks_low: assert property (!chip_select_n |->
    !sense_clock && !shift_strobe) else $error("select with clocks high");
  a_strobe_in_high: assert property (shift_strobe |-> sense_clock)
    else $error("strobe outside sense high");
  a_strobe_every_four: assert property (
    $rose(shift_strobe) && seen_ff |-> cnt_ff == 3'h4)
    else $error("strobe spacing wrong");
  a_sense_square: assert property ($rose(sense_clock) |->
    sense_clock[*5] ##1 !sense_clock) else $error("sense high time wrong");
  a_sense_low_time: assert property ($fell(sense_clock) |->
    !sense_clock[*5]) else $error("sense low time short");
  a_select_when_busy: assert property (
    !chip_select_n |-> busy && !ready) else $error("select while ready");
  a_select_one_cycle: assert property (
    $fell(chip_select_n) |=> chip_select_n) else $error("select too long");
  a_write_covers_select: assert property (
    $rose(write_n) |-> chip_select_n) else $error("write released early");
  a_page_steps_one: assert property (
    page_pos != $past(page_pos) |-> page_pos == $past(page_pos) + 8'h01)
    else $error("page position jump");
  a_found_stopped: assert property (page_found |->
    !sense_clock && !shift_strobe && !$past(page_found))
    else $error("found with clocks running");
  cover property (page_found);
  cover property ($fell(chip_select_n) && !write_n);
  cover property ($rose(shift_strobe) && seen_ff);
endmodule // ccd_ctrl_monitor
`default_nettype wire

// ### dv/ccd_mem_model.sv
// behavioural model of the short-loop serial memory
`timescale 1ns/1ps
`default_nettype none
module ccd_mem_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic sense_clock,
  input wire logic chip_select_n,
  input wire logic write_n,
  input wire logic [7:0] mem_addr,
  input wire logic mem_din,
  output var logic mem_dout
);
  logic cells [0:65535];
  logic [7:0] page_ff;
  logic sense_q_ff;
  logic last_ff;
  always_ff @(posedge clk) begin
    sense_q_ff <= sense_clock;
    if (rst) begin
      page_ff <= 8'h00;
      last_ff <= 1'b0;
    end else begin
      if (sense_q_ff && !sense_clock) begin
        page_ff <= page_ff + 8'h01;
      end
      if (!chip_select_n && !write_n) begin
        cells[{mem_addr, page_ff}] <= mem_din;
      end
      if (!chip_select_n) begin
        last_ff <= mem_dout;
      end
    end
  end
  // deselected output shows inverse of last value
  always_comb begin
    mem_dout = !chip_select_n ? cells[{mem_addr, page_ff}] : !last_ff;
  end
endmodule // ccd_mem_model
`default_nettype wire

// ### dv/ccd_page_refresh_controller_tb_top.sv
// top testbench for the page and refresh controller
`timescale 1ns/1ps
`default_nettype none
module ccd_page_refresh_controller_tb_top;
  logic clk, rst, osc_tick, search_req, access_req, access_write;
  logic serial_mode, access_din, mem_dout, sense_clock, shift_strobe;
  logic chip_select_n, write_n, mem_din, page_found, access_done, access_dout;
  logic ready, busy, mem_din_oe;
  logic [1:0] refresh_mode;
  logic [15:0] refresh_div, page_limit;
  logic [8:0] burst_len;
  logic [7:0] target_page, access_addr, mem_addr, page_pos;
  int fail_count = 0;
  int checks_done = 0;
  ccd_page_refresh_controller uut (.clk(clk), .rst(rst),
    .refresh_mode(refresh_mode), .osc_tick(osc_tick),
    .refresh_div(refresh_div), .burst_len(burst_len),
    .page_limit(page_limit), .search_req(search_req),
    .target_page(target_page), .access_req(access_req),
    .access_write(access_write), .serial_mode(serial_mode),
    .access_addr(access_addr), .access_din(access_din),
    .mem_dout(mem_dout), .sense_clock(sense_clock),
    .shift_strobe(shift_strobe), .chip_select_n(chip_select_n),
    .write_n(write_n), .mem_addr(mem_addr), .mem_din(mem_din),
    .mem_din_oe(mem_din_oe), .page_pos(page_pos), .ready(ready), .busy(busy),
    .page_found(page_found), .access_done(access_done),
    .access_dout(access_dout));
  ccd_mem_model mem (.clk(clk), .rst(rst), .sense_clock(sense_clock),
    .chip_select_n(chip_select_n), .write_n(write_n),
    .mem_addr(mem_addr), .mem_din(mem_din), .mem_dout(mem_dout));
  task automatic check(input string what, input logic [8:0] seen,
    input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d failures %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic [8:0] exp_rises(input int ticks, input int dues);
    // adaptive one per tick, distributed one per due, burst a run per due
    if (refresh_mode == 2'h2) return 9'(ticks);
    if (refresh_mode == 2'h1) return 9'(dues);
    return 9'(dues * burst_len);
  endfunction
  task automatic access(input logic wr, input logic [7:0] a, input logic d);
    int n;
    @(negedge clk);
    check("ready idle", {ready, busy}, 2'b10);
    access_write = wr;
    access_addr = a;
    access_din = d;
    serial_mode = $urandom;
    access_req = 1'b1;
    n = 0;
    while (access_done !== 1'b1 && n < 400) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("access done", n < 400, 1'b1);
    check("access busy", {ready, busy}, 2'b01);
    check("select", {write_n, chip_select_n}, {~wr, 1'b0});
    check("drive enable", mem_din_oe, wr);
    @(negedge clk);
    access_req = 1'b0;
    @(negedge clk);
  endtask
  task automatic search(input logic [7:0] t);
    int n;
    @(negedge clk);
    check("ready idle", {ready, busy}, 2'b10);
    target_page = t;
    search_req = 1'b1;
    n = 0;
    while (page_found !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    check("found page", {n < 5000, page_pos}, {1'b1, t});
    check("search busy", {ready, busy}, 2'b01);
    @(negedge clk);
    search_req = 1'b0;
    @(negedge clk);
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    #(8 * 30000);
    fail_count++;
    conclude();
  end
  initial begin
    logic [7:0] a;
    logic d, prev;
    int cnt, gap, ticks, dues, total;
    {osc_tick, search_req, access_req, access_write, serial_mode} = 5'h00;
    {access_din, target_page, access_addr} = 17'h00000;
    refresh_mode = 2'h1;
    refresh_div = 16'hffff;
    burst_len = 9'h020;
    page_limit = 16'hffff;
    rst = 1'b1;
    void'($urandom(32'h30d0519c));
    repeat (12) @(negedge clk);
    rst = 1'b0;
    search(8'h05);
    search(8'h00);
    search(8'hff);
    search($urandom);
    for (int i = 0; i < 8; i++) begin
      a = (i == 0) ? 8'hff : $urandom;
      d = $urandom;
      access(1'b1, a, d);
      access(1'b0, a, 1'b0);
      check("read data", access_dout, d);
    end
    gap = 16;
    total = 0;
    for (int m = 0; m < 3; m++) begin
      refresh_mode = 2'h2 - m[1:0];
      refresh_div = 16'h0004;
      page_limit = 16'h0010;
      burst_len = 9'($urandom_range(4, 1));
      cnt = 0;
      ticks = 0;
      dues = 0;
      prev = sense_clock;
      for (int k = 0; k < 880; k++) begin
        @(negedge clk);
        osc_tick = k < 800 && gap >= 16 && $urandom_range(3, 0) == 0;
        gap = osc_tick ? 0 : gap + 1;
        ticks += osc_tick;
        total += osc_tick;
        dues += osc_tick && total % 4 == 0;
        cnt += (sense_clock && !prev);
        prev = sense_clock;
      end
      check("refresh clocks", cnt != 0, 1'b1);
      check("refresh count", cnt, exp_rises(ticks, dues));
    end
    osc_tick = 1'b0;
    conclude();
  end
endmodule // ccd_page_refresh_controller_tb_top
bind ccd_page_refresh_controller ccd_ctrl_monitor mon (.clk(clk), .rst(rst),
  .sense_clock(sense_clock), .shift_strobe(shift_strobe),
  .chip_select_n(chip_select_n), .write_n(write_n),
  .page_pos(page_pos), .page_found(page_found), .ready(ready), .busy(busy));
`default_nettype wire
